// ===== sbrm_pkg.sv
// Purpose: Shared constants and types of the system bus read master.
// Assumes: A 36-bit physical address and a 64-bit read data path.
// Notes: The widths, counts and the address, byte-enable and strobe reset values of the block are named here.

package sbrm_pkg;

   // ---------------------------------------------------------------------
   // Widths and counts
   // ---------------------------------------------------------------------
   localparam int ADDR_W = 36;
   localparam int DATA_W = 64;
   localparam int BE_W = 8;
   localparam int BEATS = 4;
   localparam int BEAT_W = 2;
   localparam int LINE_LSB = 5;
   localparam int SYNC_STAGES = 2;

   // ---------------------------------------------------------------------
   // Values
   // ---------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] BEAT_STEP = 36'h0_0000_0008;
   localparam logic [ADDR_W-1:0] ADDR_RST = 36'h0_0000_0000;
   localparam logic [BE_W-1:0] BE_ALL_N = 8'h00;
   localparam logic [BE_W-1:0] BE_NONE_N = 8'hFF;
   localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
   localparam logic [BEAT_W-1:0] BEAT_PENULT = 2'h2;
   localparam logic [BEAT_W-1:0] BEAT_FINAL = 2'h3;
   localparam logic STROBE_OFF = 1'b1;
   localparam logic STROBE_ON = 1'b0;

   // ---------------------------------------------------------------------
   // Bus sequencer states
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      SBRM_IDLE = 3'h0,
      SBRM_SGL_ACK = 3'h1,
      SBRM_SGL_CAP = 3'h3,
      SBRM_BST_WAIT = 3'h4,
      SBRM_BST_CAP = 3'h5
   } sbrm_state_t;

endpackage

// ===== sbrm_sync.sv
// Purpose: Two-stage synchroniser for levels and toggles.
// Assumes: The input is a level that changes no faster than the clock.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/1ns

module sbrm_sync
   import sbrm_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end

endmodule

// ===== sbrm_read_master.sv
// Purpose: Read master of the system bus: single reads and line refills.
// Assumes: Bus pins are synchronous to the system bus clock.
// Notes: Requests and results cross between clocks by toggle handshakes.
//
// Overview of operation
// - All bus strobes and samples happen on rising system bus clock edges.
// - Transfers of eight bytes or less use a single read.
// - Single read starts with begin, read and final-beat strobes together.
// - Begin lasts one cycle; final drops on ack; data taken next edge.
// - Address and qualifiers stay stable until the read completes.
// - A directly following read keeps the read strobe asserted.
// - Bus error ends a single read, read strobe released at that edge.
// - Bus error is sampled every edge up to the capture edge.
// - Data with bus error at the capture edge is discarded.
// - A single read ended by bus error raises a bus error exception.
// - Cache line refills of 32 bytes use a burst read.
// - During a burst all byte enables and cacheable are driven low.
// - Burst starts with read and multi-beat strobes and valid qualifiers.
// - Burst starts at line base; address steps by eight per beat.
// - At each capture edge ack for the next beat is sampled.
// - Final-beat asserts when ack for the next-to-last beat is seen.
// - Final-beat deasserts when ack for the last beat is seen.
// - After the last beat read and multi-beat strobes are released.
// - A following read or burst keeps its strobes asserted, no gap.
// - Bus error ends a burst, invalidates the line, raises an exception.
// - Access kind is low for data and high for instruction fetch.

`timescale 1ns/1ns

module sbrm_read_master
   import sbrm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic [ADDR_W-1:0] i_req_addr,
   input wire logic [BE_W-1:0] i_req_byte_en,
   input wire logic i_req_cacheable,
   input wire logic i_req_fetch,
   input wire logic i_req_refill,
   output logic o_rsp_valid,
   output logic [BEATS*DATA_W-1:0] o_rsp_data,
   output logic o_rsp_refill,
   output logic o_rsp_bus_error,
   output logic o_rsp_invalidate,
   input wire logic i_system_bus_clock,
   output logic [ADDR_W-1:0] o_bus_address_out,
   output logic [BE_W-1:0] o_byte_lane_enable_n,
   output logic o_cacheable_access_n,
   output logic o_access_kind,
   output logic o_transfer_begin_n,
   output logic o_read_strobe_n,
   output logic o_final_beat_n,
   output logic o_multi_beat_n,
   input wire logic [DATA_W-1:0] i_read_data_in,
   input wire logic i_transfer_ack_n,
   input wire logic i_bus_error_n
);

   // ---------------------------------------------------------------------
   // Resets
   // ---------------------------------------------------------------------
   logic rst_n;
   logic brst_n;

   sbrm_sync #(.W(1)) u_rst_core (
      .i_clk(i_clk),
      .i_rst_n(i_reset_n),
      .i_d(1'b1),
      .o_q(rst_n)
   );

   sbrm_sync #(.W(1)) u_rst_bus (
      .i_clk(i_system_bus_clock),
      .i_rst_n(i_reset_n),
      .i_d(1'b1),
      .o_q(brst_n)
   );

   // ---------------------------------------------------------------------
   // Core side request holding
   // ---------------------------------------------------------------------
   logic req_tgl_r;
   logic ack_sync;
   logic [ADDR_W-1:0] hold_addr_r;
   logic [BE_W-1:0] hold_be_r;
   logic hold_cache_r;
   logic hold_fetch_r;
   logic hold_refill_r;

   // A new request may be offered once the bus side has taken the last one.
   assign o_req_ready = (ack_sync == req_tgl_r);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_tgl_r <= 1'b0;
         hold_addr_r <= ADDR_RST;
         hold_be_r <= BE_NONE_N;
         hold_cache_r <= 1'b0;
         hold_fetch_r <= 1'b0;
         hold_refill_r <= 1'b0;
      end else if (i_req_valid && o_req_ready) begin
         req_tgl_r <= ~req_tgl_r;
         hold_addr_r <= i_req_addr;
         hold_be_r <= i_req_byte_en;
         hold_cache_r <= i_req_cacheable;
         hold_fetch_r <= i_req_fetch;
         hold_refill_r <= i_req_refill;
      end
   end

   // ---------------------------------------------------------------------
   // Bus side request pickup
   // ---------------------------------------------------------------------
   logic req_sync;
   logic req_seen_r;
   logic pend;
   sbrm_state_t state_r;
   logic [BEAT_W-1:0] beat_r;
   logic done_tgl_r;
   logic bus_err;
   logic cap_ok;
   logic finish_now;
   logic start_now;
   logic start_bst;

   sbrm_sync #(.W(1)) u_req_sync (
      .i_clk(i_system_bus_clock),
      .i_rst_n(brst_n),
      .i_d(req_tgl_r),
      .o_q(req_sync)
   );

   sbrm_sync #(.W(1)) u_ack_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(req_seen_r),
      .o_q(ack_sync)
   );

   assign pend = (req_sync != req_seen_r);
   assign start_bst = hold_refill_r;

   always_comb begin
      bus_err = 1'b0;
      cap_ok = 1'b0;
      finish_now = 1'b0;
      case (state_r)
         SBRM_SGL_ACK: begin
            bus_err = !i_bus_error_n;
            finish_now = bus_err;
         end
         SBRM_SGL_CAP: begin
            bus_err = !i_bus_error_n;
            cap_ok = !bus_err;
            finish_now = 1'b1;
         end
         SBRM_BST_WAIT: begin
            bus_err = !i_bus_error_n;
            finish_now = bus_err;
         end
         SBRM_BST_CAP: begin
            bus_err = !i_bus_error_n;
            cap_ok = !bus_err;
            finish_now = bus_err || (beat_r == BEAT_FINAL);
         end
         default: begin
            bus_err = 1'b0;
         end
      endcase
      start_now = pend && ((state_r == SBRM_IDLE) || finish_now);
   end

   always_ff @(posedge i_system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         req_seen_r <= 1'b0;
      end else if (start_now) begin
         req_seen_r <= req_sync;
      end
   end

   // ---------------------------------------------------------------------
   // Bus sequencer and strobes
   // ---------------------------------------------------------------------
   // All strobes change on the rising bus clock edge only.
   always_ff @(posedge i_system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         state_r <= SBRM_IDLE;
         o_transfer_begin_n <= STROBE_OFF;
         o_read_strobe_n <= STROBE_OFF;
         o_final_beat_n <= STROBE_OFF;
         o_multi_beat_n <= STROBE_OFF;
      end else if (start_now) begin
         // Back-to-back reads keep the read strobe low.
         o_transfer_begin_n <= STROBE_ON;
         o_read_strobe_n <= STROBE_ON;
         o_final_beat_n <= start_bst ? STROBE_OFF : STROBE_ON;
         o_multi_beat_n <= start_bst ? STROBE_ON : STROBE_OFF;
         state_r <= start_bst ? SBRM_BST_WAIT : SBRM_SGL_ACK;
      end else if (finish_now) begin
         o_transfer_begin_n <= STROBE_OFF;
         o_read_strobe_n <= STROBE_OFF;
         o_final_beat_n <= STROBE_OFF;
         o_multi_beat_n <= STROBE_OFF;
         state_r <= SBRM_IDLE;
      end else begin
         o_transfer_begin_n <= STROBE_OFF;
         case (state_r)
            SBRM_SGL_ACK: begin
               if (!i_transfer_ack_n) begin
                  o_final_beat_n <= STROBE_OFF;
                  state_r <= SBRM_SGL_CAP;
               end
            end
            SBRM_BST_WAIT: begin
               if (!i_transfer_ack_n) begin
                  if (beat_r == BEAT_PENULT) begin
                     o_final_beat_n <= STROBE_ON;
                  end
                  if (beat_r == BEAT_FINAL) begin
                     o_final_beat_n <= STROBE_OFF;
                  end
                  state_r <= SBRM_BST_CAP;
               end
            end
            SBRM_BST_CAP: begin
               // Ack for the next beat is sampled at the capture edge.
               if (!i_transfer_ack_n) begin
                  if (beat_r + 2'h1 == BEAT_PENULT) begin
                     o_final_beat_n <= STROBE_ON;
                  end
                  if (beat_r + 2'h1 == BEAT_FINAL) begin
                     o_final_beat_n <= STROBE_OFF;
                  end
               end else begin
                  state_r <= SBRM_BST_WAIT;
               end
            end
            default: begin
               state_r <= state_r;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Address, qualifiers and beat count
   // ---------------------------------------------------------------------
   // Qualifiers move only at a start or a beat step, so they hold.
   always_ff @(posedge i_system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         o_bus_address_out <= ADDR_RST;
         o_byte_lane_enable_n <= BE_NONE_N;
         o_cacheable_access_n <= STROBE_OFF;
         o_access_kind <= 1'b0;
      end else if (start_now) begin
         o_access_kind <= hold_fetch_r;
         if (start_bst) begin
            // Refill starts at the lowest doubleword of the line.
            o_bus_address_out <= {hold_addr_r[ADDR_W-1:LINE_LSB],
                                  {LINE_LSB{1'b0}}};
            o_byte_lane_enable_n <= BE_ALL_N;
            o_cacheable_access_n <= STROBE_ON;
         end else begin
            o_bus_address_out <= hold_addr_r;
            o_byte_lane_enable_n <= hold_be_r;
            o_cacheable_access_n <= ~hold_cache_r;
         end
      end else if (cap_ok && (state_r == SBRM_BST_CAP) &&
                   (beat_r != BEAT_FINAL)) begin
         o_bus_address_out <= o_bus_address_out + BEAT_STEP;
      end
   end

   always_ff @(posedge i_system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         beat_r <= BEAT_FIRST;
      end else if (start_now) begin
         beat_r <= BEAT_FIRST;
      end else if (cap_ok && (state_r == SBRM_BST_CAP)) begin
         beat_r <= beat_r + 2'h1;
      end
   end

   // ---------------------------------------------------------------------
   // Result slots
   // ---------------------------------------------------------------------
   // Two slots let a result be read by the core while the next one fills.
   logic [DATA_W-1:0] slot_data_r [2][BEATS];
   logic slot_err_r [2];
   logic slot_bst_r [2];
   logic wslot;

   assign wslot = ~done_tgl_r;

   always_ff @(posedge i_system_bus_clock) begin
      if (cap_ok) begin
         if (state_r == SBRM_BST_CAP) begin
            slot_data_r[wslot][beat_r] <= i_read_data_in;
         end else begin
            slot_data_r[wslot][BEAT_FIRST] <= i_read_data_in;
         end
      end
   end

   always_ff @(posedge i_system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         done_tgl_r <= 1'b0;
         slot_err_r[0] <= 1'b0;
         slot_err_r[1] <= 1'b0;
         slot_bst_r[0] <= 1'b0;
         slot_bst_r[1] <= 1'b0;
      end else if (finish_now) begin
         slot_err_r[wslot] <= bus_err;
         slot_bst_r[wslot] <= (state_r == SBRM_BST_WAIT) ||
                              (state_r == SBRM_BST_CAP);
         done_tgl_r <= ~done_tgl_r;
      end
   end

   // ---------------------------------------------------------------------
   // Core side result delivery
   // ---------------------------------------------------------------------
   logic done_sync;
   logic done_seen_r;

   sbrm_sync #(.W(1)) u_done_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_d(done_tgl_r),
      .o_q(done_sync)
   );

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_seen_r <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_refill <= 1'b0;
         o_rsp_bus_error <= 1'b0;
         o_rsp_invalidate <= 1'b0;
         o_rsp_data <= '0;
      end else begin
         done_seen_r <= done_sync;
         o_rsp_valid <= 1'b0;
         o_rsp_bus_error <= 1'b0;
         o_rsp_invalidate <= 1'b0;
         if (done_sync != done_seen_r) begin
            o_rsp_refill <= slot_bst_r[done_sync];
            o_rsp_bus_error <= slot_err_r[done_sync];
            o_rsp_invalidate <= slot_err_r[done_sync] &&
                                slot_bst_r[done_sync];
            // An errored read delivers no data.
            o_rsp_valid <= !slot_err_r[done_sync];
            if (!slot_err_r[done_sync]) begin
               for (int i = 0; i < BEATS; i++) begin
                  o_rsp_data[i*DATA_W +: DATA_W] <=
                     slot_data_r[done_sync][i];
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   property p_idle_strobes;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_IDLE) |-> (o_read_strobe_n && o_multi_beat_n &&
                                  o_final_beat_n && o_transfer_begin_n);
   endproperty
   a_idle_strobes: assert property (p_idle_strobes)
      else $error("strobe asserted while idle");

   property p_begin_one;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (!o_transfer_begin_n && !pend) |=> o_transfer_begin_n;
   endproperty
   a_begin_one: assert property (p_begin_one)
      else $error("begin strobe held longer than one cycle");

   property p_single_start;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (!o_transfer_begin_n && o_multi_beat_n) |->
         (!o_read_strobe_n && !o_final_beat_n &&
          state_r == SBRM_SGL_ACK);
   endproperty
   a_single_start: assert property (p_single_start)
      else $error("single read did not start with all strobes");

   property p_burst_qual;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      !o_multi_beat_n |-> (o_byte_lane_enable_n == BE_ALL_N &&
                           !o_cacheable_access_n && !o_read_strobe_n);
   endproperty
   a_burst_qual: assert property (p_burst_qual)
      else $error("burst qualifiers not driven low");

   property p_wait_hold;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_SGL_ACK && i_transfer_ack_n && i_bus_error_n)
      |=> ($stable(o_bus_address_out) && $stable(o_byte_lane_enable_n) &&
           $stable(o_read_strobe_n) && $stable(o_final_beat_n));
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("outputs moved during a wait cycle");

   property p_err_end;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_SGL_ACK && !i_bus_error_n && !pend)
      |=> (o_read_strobe_n && state_r == SBRM_IDLE && slot_err_r[~wslot]);
   endproperty
   a_err_end: assert property (p_err_end)
      else $error("bus error did not end the single read");

   property p_addr_step;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_BST_CAP && i_bus_error_n && beat_r != BEAT_FINAL)
      |=> (o_bus_address_out == $past(o_bus_address_out) + BEAT_STEP);
   endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("burst address did not advance by eight");

   property p_last_on;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_BST_CAP && beat_r == 2'h1 && !i_transfer_ack_n &&
       i_bus_error_n) |=> !o_final_beat_n;
   endproperty
   a_last_on: assert property (p_last_on)
      else $error("final-beat strobe not asserted in time");

   property p_last_off;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_BST_CAP && beat_r == BEAT_PENULT &&
       !i_transfer_ack_n && i_bus_error_n) |=> o_final_beat_n;
   endproperty
   a_last_off: assert property (p_last_off)
      else $error("final-beat strobe not released in time");

   property p_b2b;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (finish_now && pend) |=> (!o_read_strobe_n && !o_transfer_begin_n);
   endproperty
   a_b2b: assert property (p_b2b)
      else $error("gap between back-to-back reads");

   property p_burst_end;
      @(posedge i_system_bus_clock) disable iff (!brst_n)
      (state_r == SBRM_BST_CAP && beat_r == BEAT_FINAL && !pend)
      |=> (o_read_strobe_n && o_multi_beat_n);
   endproperty
   a_burst_end: assert property (p_burst_end)
      else $error("burst strobes not released after last beat");

   c_single: cover property (@(posedge i_system_bus_clock)
      state_r == SBRM_SGL_CAP && i_bus_error_n);
   c_burst: cover property (@(posedge i_system_bus_clock)
      state_r == SBRM_BST_CAP && beat_r == BEAT_FINAL && i_bus_error_n);
   c_error: cover property (@(posedge i_system_bus_clock)
      bus_err && state_r == SBRM_BST_WAIT);
   c_b2b: cover property (@(posedge i_system_bus_clock)
      finish_now && pend);

endmodule

// ===== sbrm_bus_model.sv
// Purpose: Behavioural model of the memory controller on the system bus.
// Assumes: The bench sets wait and error controls between transactions.
// Notes: Read data outside a capture cycle is the inverse of the pattern.

`timescale 1ns/1ns

module sbrm_bus_model
   import sbrm_pkg::*;
(
   input wire logic i_system_bus_clock,
   input wire logic i_reset_n,
   input wire logic [ADDR_W-1:0] i_bus_address_out,
   input wire logic i_transfer_begin_n,
   input wire logic i_read_strobe_n,
   input wire logic [1:0] i_wait,
   input wire logic i_err_en,
   input wire logic [2:0] i_err_at,
   output logic [DATA_W-1:0] o_read_data_in,
   output logic o_transfer_ack_n,
   output logic o_bus_error_n
);
   logic [1:0] wcnt_r;
   logic [2:0] ecnt_r;
   logic ack_q_r;
   logic [1:0] cur;
   logic [DATA_W-1:0] pat;

   // -------------------------------------------------------------------
   // Answer logic
   // -------------------------------------------------------------------
   assign cur = i_transfer_begin_n ? wcnt_r : 2'h0;
   assign o_transfer_ack_n = !(!i_read_strobe_n && cur == i_wait);
   assign o_bus_error_n = !(i_err_en && !i_read_strobe_n &&
      i_transfer_begin_n && ecnt_r == i_err_at);
   assign pat = {28'h000_0000, i_bus_address_out} ^ 64'h5A5A_0000_0000_0000;
   assign o_read_data_in = ack_q_r ? pat : ~pat;

   always_ff @(posedge i_system_bus_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wcnt_r <= 2'h0;
         ecnt_r <= 3'h0;
         ack_q_r <= 1'b0;
      end else begin
         ack_q_r <= !o_transfer_ack_n;
         if (i_read_strobe_n || !o_transfer_ack_n) begin
            wcnt_r <= 2'h0;
         end else if (!i_transfer_begin_n) begin
            wcnt_r <= 2'h1;
         end else begin
            wcnt_r <= wcnt_r + 2'h1;
         end
         if (!i_transfer_begin_n) begin
            ecnt_r <= 3'h1;
         end else if (!i_read_strobe_n) begin
            ecnt_r <= ecnt_r + 3'h1;
         end
      end
   end
endmodule

// ===== system_bus_read_master_test.sv
// Purpose: Self-checking bench of the system bus read master.
// Assumes: Core clock 20 ns, bus clock 32 ns, no phase relation.
// Notes: Expected data is a pattern of the address of each beat.

`timescale 1ns/1ns

module system_bus_read_master_test
   import sbrm_pkg::*;
;
   logic i_clk = 1'b0;
   logic bclk = 1'b0;
   logic i_reset_n = 1'b0;
   logic rv = 1'b0, rc = 1'b0, rf = 1'b0, rr = 1'b0;
   logic [ADDR_W-1:0] ra = 36'h0_0000_0000;
   logic [BE_W-1:0] rb = 8'hFF;
   logic [1:0] mw = 2'h0;
   logic me = 1'b0, kind = 1'b0, rd_prev = 1'b1;
   logic [2:0] mat = 3'h0;
   logic o_req_ready, o_rsp_valid, o_rsp_refill, o_rsp_bus_error;
   logic o_rsp_invalidate, o_cacheable_access_n, o_access_kind;
   logic o_transfer_begin_n, o_read_strobe_n, o_final_beat_n, o_multi_beat_n;
   logic ack_n, err_n;
   logic [BEATS*DATA_W-1:0] o_rsp_data;
   logic [ADDR_W-1:0] o_bus_address_out;
   logic [BE_W-1:0] o_byte_lane_enable_n;
   logic [DATA_W-1:0] rdata;
   int n_fail = 0, checks_done = 0, rises = 0;

   always #10 i_clk = ~i_clk;
   always #16 bclk = ~bclk;

   sbrm_read_master sbrm_read_master_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_req_valid(rv), .o_req_ready(o_req_ready), .i_req_addr(ra),
      .i_req_byte_en(rb), .i_req_cacheable(rc), .i_req_fetch(rf),
      .i_req_refill(rr), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
      .o_rsp_refill(o_rsp_refill), .o_rsp_bus_error(o_rsp_bus_error),
      .o_rsp_invalidate(o_rsp_invalidate), .i_system_bus_clock(bclk),
      .o_bus_address_out(o_bus_address_out),
      .o_byte_lane_enable_n(o_byte_lane_enable_n),
      .o_cacheable_access_n(o_cacheable_access_n),
      .o_access_kind(o_access_kind), .o_transfer_begin_n(o_transfer_begin_n),
      .o_read_strobe_n(o_read_strobe_n), .o_final_beat_n(o_final_beat_n),
      .o_multi_beat_n(o_multi_beat_n), .i_read_data_in(rdata),
      .i_transfer_ack_n(ack_n), .i_bus_error_n(err_n));

   sbrm_bus_model sbrm_bus_model_i (.i_system_bus_clock(bclk),
      .i_reset_n(i_reset_n), .i_bus_address_out(o_bus_address_out),
      .i_transfer_begin_n(o_transfer_begin_n),
      .i_read_strobe_n(o_read_strobe_n), .i_wait(mw), .i_err_en(me),
      .i_err_at(mat), .o_read_data_in(rdata), .o_transfer_ack_n(ack_n),
      .o_bus_error_n(err_n));

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic wrap_up();
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [63:0] pat(input logic [ADDR_W-1:0] a);
      return {28'h000_0000, a} ^ 64'h5A5A_0000_0000_0000;
   endfunction

   function automatic logic [255:0] line(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] b;
      b = a & ~36'h0_0000_001F;
      return {pat(b + 36'h18), pat(b + 36'h10), pat(b + 36'h8), pat(b)};
   endfunction

   // Burst qualifiers are watched at every bus edge with multi-beat asserted, access kind at each edge with begin asserted.
   always @(posedge bclk) begin
      rd_prev <= o_read_strobe_n;
      if (!rd_prev && o_read_strobe_n === 1'b1) rises++;
      if (o_multi_beat_n === 1'b0) begin
         chk(o_byte_lane_enable_n, 8'h00);
         chk(o_cacheable_access_n, 1'b0);
      end
      if (o_transfer_begin_n === 1'b0) chk(o_access_kind, kind);
      if (o_transfer_begin_n === 1'b0 && o_multi_beat_n === 1'b1) begin
         chk(o_bus_address_out, ra);
         chk(o_byte_lane_enable_n, rb);
         chk(o_cacheable_access_n, !rc);
      end
   end

   task automatic setup(input logic [1:0] w, input logic e, input logic [2:0] at);
      @(posedge i_clk);
      mw <= w;
      me <= e;
      mat <= at;
   endtask

   task automatic issue(input logic [ADDR_W-1:0] a, input logic b, f);
      int k;
      for (k = 0; k < 200; k++) begin
         @(posedge i_clk);
         if (o_req_ready === 1'b1) break;
      end
      if (k == 200) begin
         n_fail++;
         wrap_up();
      end
      kind = f;
      rv <= 1'b1;
      ra <= a;
      rr <= b;
      rf <= f;
      rb <= a[11:4];
      rc <= a[3];
      @(posedge i_clk);
      rv <= 1'b0;
   endtask

   task automatic collect(input logic e, v, b, input logic [255:0] exp);
      int k;
      logic [255:0] old;
      old = o_rsp_data;
      for (k = 0; k < 300; k++) begin
         @(posedge i_clk);
         #1;
         if (o_rsp_valid === 1'b1 || o_rsp_bus_error === 1'b1) break;
      end
      if (k == 300) begin
         n_fail++;
         wrap_up();
      end
      chk(o_rsp_bus_error, e);
      chk(o_rsp_invalidate, v);
      if (e) begin
         chk(o_rsp_data, old);
      end else begin
         chk(o_rsp_refill, b);
         chk(b ? o_rsp_data : o_rsp_data[63:0], exp);
      end
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_single(input logic [1:0] w);
      setup(w, 1'b0, 3'h0);
      issue(36'h1_2345_6788 + w, 1'b0, w[0]);
      collect(1'b0, 1'b0, 1'b0, pat(36'h1_2345_6788 + w));
   endtask

   task automatic t_burst(input logic [1:0] w, input logic e);
      setup(w, e, 3'h4);
      issue(36'h8_0000_0137, 1'b1, 1'b1);
      collect(e, e, 1'b1, line(36'h8_0000_0137));
   endtask

   // Error at the ack edge after one wait (w=1) and at the capture edge (w=0).
   task automatic t_err(input logic [1:0] w);
      setup(w, 1'b1, 3'h1);
      issue(36'h0_0000_0010 + w, 1'b0, 1'b0);
      collect(1'b1, 1'b0, 1'b0, 256'h0);
   endtask

   task automatic t_b2b();
      int r0;
      setup(2'h3, 1'b0, 3'h0);
      r0 = rises;
      issue(36'h0_0000_0240, 1'b1, 1'b0);
      issue(36'h0_0000_0308, 1'b0, 1'b0);
      collect(1'b0, 1'b0, 1'b1, line(36'h0_0000_0240));
      collect(1'b0, 1'b0, 1'b0, pat(36'h0_0000_0308));
      repeat (4) @(posedge bclk);
      chk(rises - r0, 1);
   endtask

   initial begin
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (10) @(posedge i_clk);
      chk({o_transfer_begin_n, o_read_strobe_n, o_multi_beat_n}, 3'h7);
      t_single(2'h0);
      t_single(2'h2);
      t_err(2'h1);
      t_err(2'h0);
      t_burst(2'h0, 1'b0);
      t_burst(2'h1, 1'b0);
      t_burst(2'h0, 1'b1);
      t_b2b();
      wrap_up();
   end
endmodule
